// file: design/cim_pkg.sv
package cim_pkg;
  // ==========================================================
  // register file numbering
  localparam logic [4:0] REG_LOW_BASE     = 5'h10; // codes 0 and 1 land here
  localparam logic [2:0] CODE_LOW_LIMIT   = 3'h2;  // codes below this are remapped
  localparam logic [4:0] COMPARE_FLAG_REG = 5'h18;
  localparam logic [4:0] STACK_TOP_REG    = 5'h1d;
  localparam logic [4:0] RETURN_LINK_REG  = 5'h1f;

  // ==========================================================
  // mode encoding
  localparam logic MODE_WIDE    = 1'b0; // 32-bit instructions
  localparam logic MODE_COMPACT = 1'b1; // 16-bit instructions
  localparam int   MODE_BIT     = 0;    // pc / link bit carrying the mode

  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_MODE   = 4'h8;
  localparam int         EVT_W       = 4;
  localparam int         EVT_EXT_RI  = 0; // misplaced extend prefix
  localparam int         EVT_JMP_RI  = 1; // exchange jump without extension, or compact register jump outside compact mode
  localparam int         EVT_ADDR    = 2; // odd register-jump target
  localparam int         EVT_BREAK   = 3; // compact breakpoint
  localparam logic [EVT_W-1:0] STATUS_RST = 4'h0;
  localparam logic [EVT_W-1:0] MASK_RST   = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CL_LDST, CL_SAVE, CL_ALUI, CL_SHIFTI, CL_BRANCH, CL_MACRO,
    CL_ALUR, CL_MOVE, CL_MULDIV, CL_JUMP, CL_BREAK, CL_EXTEND
  } cim_class_t;

  typedef enum logic [2:0] {
    JK_JAL, JK_JUMP_LINK_EXCHANGE, JK_JR, JK_JUMP_VIA_REG_HAZARD, JK_JUMP_LINK_VIA_REG, JK_JUMP_LINK_VIA_REG_HAZARD, JK_JRC, JK_COMPACT_JUMP_LINK_VIA_REG
  } cim_jkind_t;

  typedef enum logic [1:0] {EX_NORMAL, EX_ERROR, EX_DEBUG} cim_exkind_t;

  typedef struct packed {
    cim_class_t cls;
    logic       flag_use;  // compare, set-on-less-than, flag branch
    logic       sp_use;
    logic       ra_use;
    logic [2:0] rx;
    logic [2:0] ry;
    logic [4:0] move_reg;  // full index for the move forms
  } cim_dec_req_t;

  typedef struct packed {
    logic [4:0] rx_idx;
    logic [4:0] ry_idx;
    logic [4:0] imp_idx;
    logic       imp_vld;
    logic       extensible;
    logic       ri;        // reserved-instruction from extend misuse
    logic       brk;
    logic       macro;
  } cim_dec_rsp_t;
endpackage : cim_pkg

// file: design/cim_regmap.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Operation
// - codes 0,1 map to 16,17
// - flag instructions implicitly use register 24
// - stack and link use 29, 31
// - move forms name any register
// - one mode bit, 1 means compact
// - exceptions and reset clear mode
// - exception restart bit 0 holds mode
// - reset fetch starts wide at vector
// - linking jumps store mode in bit0
// - exchange jump inverts the mode
// - register jumps load mode, clear pc0
// - compact register jumps same in compact
// - no extension: exchange jump reserved
// - no extension: odd register-jump target address error
// - breakpoint traps; extend widens next
// - macro instructions flagged for expansion
// - misplaced extend raises reserved instruction
module cim_regmap #(
  parameter bit          HAS_COMPACT = 1'b1,
  parameter logic [31:0] RESET_VEC   = 32'h0000_0000
) (
  input  wire logic                         clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic [3:0]                   reg_addr_in,
  input  wire logic [31:0]                  reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [31:0]                  reg_rdata_out,
  output logic                              irq_out,
  input  wire logic                         dec_valid_in,
  input  wire cim_pkg::cim_dec_req_t        dec_req_in,
  output logic                              dec_valid_out,
  output cim_pkg::cim_dec_rsp_t             dec_rsp_out,
  input  wire logic                         jmp_valid_in,
  input  wire cim_pkg::cim_jkind_t          jmp_kind_in,
  input  wire logic [31:0]                  jmp_target_in,
  output logic                              jmp_link_vld_out,
  output logic                              jmp_link_bit_out,
  output logic                              jmp_ri_out,
  output logic                              jmp_addr_err_out,
  input  wire logic                         exc_take_in,
  input  wire cim_pkg::cim_exkind_t         exc_kind_in,
  output logic                              exc_vld_out,
  output cim_pkg::cim_exkind_t              exc_dest_out,
  output logic                              exc_restart_bit_out,
  output logic                              fetch_mode_out,
  output logic                              fetch_redirect_out,
  output logic      [31:0]                  fetch_pc_out
);

  typedef enum logic {ST_IDLE, ST_EXT_PEND} cim_ext_st_t;

  // ==========================================================
  // helpers
  // compact field to file index
  function automatic logic [4:0] map_code(input logic [2:0] code);
    map_code = (code < cim_pkg::CODE_LOW_LIMIT) ? (cim_pkg::REG_LOW_BASE | {2'h0, code}) : {2'h0, code};
  endfunction : map_code

  // categories that accept an extend prefix
  function automatic logic is_extensible(input cim_pkg::cim_class_t cls);
    is_extensible = (cls == cim_pkg::CL_LDST) || (cls == cim_pkg::CL_SAVE) ||
                    (cls == cim_pkg::CL_ALUI) || (cls == cim_pkg::CL_SHIFTI) ||
                    (cls == cim_pkg::CL_BRANCH) || (cls == cim_pkg::CL_MACRO);
  endfunction : is_extensible

  // ==========================================================
  // state
  logic                           mode_q, mode_d;
  cim_ext_st_t                    ext_q, ext_d;
  logic [cim_pkg::EVT_W-1:0]      status_q, status_d, mask_q;
  logic                           rst_pend_q;
  logic [31:0]                    pc_q;
  logic                           redir_q;
  cim_pkg::cim_dec_rsp_t          rsp_d;
  logic [cim_pkg::EVT_W-1:0]      evt;

  // ==========================================================
  // decode path
  wire cim_pkg::cim_class_t cls      = dec_req_in.cls;
  wire logic                is_ext   = (cls == cim_pkg::CL_EXTEND);
  wire logic                is_move  = (cls == cim_pkg::CL_MOVE);
  wire logic                pend     = (ext_q == ST_EXT_PEND);
  wire logic                ext_bad  = dec_valid_in && pend && (is_ext || !is_extensible(cls));

  wire logic [4:0] rx_map = map_code(dec_req_in.rx);
  wire logic [4:0] ry_map = map_code(dec_req_in.ry);

  // response assembly
  always_comb begin
    rsp_d            = '0;
    rsp_d.rx_idx     = is_move ? dec_req_in.move_reg : rx_map;
    rsp_d.ry_idx     = ry_map;
    rsp_d.imp_vld    = dec_req_in.flag_use || dec_req_in.sp_use || dec_req_in.ra_use;
    if (dec_req_in.flag_use) begin
      rsp_d.imp_idx = cim_pkg::COMPARE_FLAG_REG;
    end else if (dec_req_in.sp_use) begin
      rsp_d.imp_idx = cim_pkg::STACK_TOP_REG;
    end else if (dec_req_in.ra_use) begin
      rsp_d.imp_idx = cim_pkg::RETURN_LINK_REG;
    end
    rsp_d.extensible = is_extensible(cls);
    rsp_d.ri         = ext_bad;
    rsp_d.brk        = (cls == cim_pkg::CL_BREAK);
    rsp_d.macro      = (cls == cim_pkg::CL_MACRO);
  end

  always_comb begin
    ext_d = ext_q;
    if (exc_take_in) begin
      ext_d = ST_IDLE;
    end else if (dec_valid_in) begin
      unique case (ext_q)
        ST_IDLE:     ext_d = is_ext ? ST_EXT_PEND : ST_IDLE;
        ST_EXT_PEND: ext_d = is_ext ? ST_EXT_PEND : ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // jump and mode path
  wire logic jv        = jmp_valid_in && !exc_take_in;
  wire logic k_jump_link_exchange    = (jmp_kind_in == cim_pkg::JK_JUMP_LINK_EXCHANGE);
  wire logic k_reg     = (jmp_kind_in == cim_pkg::JK_JR) || (jmp_kind_in == cim_pkg::JK_JUMP_VIA_REG_HAZARD) ||
                         (jmp_kind_in == cim_pkg::JK_JUMP_LINK_VIA_REG) || (jmp_kind_in == cim_pkg::JK_JUMP_LINK_VIA_REG_HAZARD);
  wire logic k_cmp     = (jmp_kind_in == cim_pkg::JK_JRC) || (jmp_kind_in == cim_pkg::JK_COMPACT_JUMP_LINK_VIA_REG);
  wire logic k_link    = (jmp_kind_in == cim_pkg::JK_JAL) || k_jump_link_exchange || (jmp_kind_in == cim_pkg::JK_JUMP_LINK_VIA_REG) ||
                         (jmp_kind_in == cim_pkg::JK_JUMP_LINK_VIA_REG_HAZARD) || (jmp_kind_in == cim_pkg::JK_COMPACT_JUMP_LINK_VIA_REG);
  wire logic tgt_lsb   = jmp_target_in[cim_pkg::MODE_BIT];
  wire logic jump_link_exchange_ri   = jv && k_jump_link_exchange && !HAS_COMPACT;
  // compact register jumps only exist in compact mode
  wire logic cmp_ri    = jv && k_cmp && !(HAS_COMPACT && mode_q == cim_pkg::MODE_COMPACT);
  wire logic jmp_ri    = jump_link_exchange_ri || cmp_ri;
  wire logic addr_err  = jv && k_reg && !HAS_COMPACT && tgt_lsb;
  wire logic mode_load = jv && HAS_COMPACT && (k_reg || (k_cmp && mode_q == cim_pkg::MODE_COMPACT));
  wire logic redirect  = jv && !jmp_ri && !addr_err;
  wire logic [31:0] tgt_clr = {jmp_target_in[31:1], 1'b0};

  always_comb begin
    mode_d = mode_q;
    if (exc_take_in) begin
      mode_d = cim_pkg::MODE_WIDE;
    end else if (jv && k_jump_link_exchange && HAS_COMPACT) begin
      mode_d = ~mode_q;
    end else if (mode_load) begin
      mode_d = tgt_lsb;
    end
  end

  // ==========================================================
  // sticky events, set wins over write-one clear
  assign evt[cim_pkg::EVT_EXT_RI] = ext_bad;
  assign evt[cim_pkg::EVT_JMP_RI] = jmp_ri;
  assign evt[cim_pkg::EVT_ADDR]   = addr_err;
  assign evt[cim_pkg::EVT_BREAK]  = dec_valid_in && (cls == cim_pkg::CL_BREAK);

  wire logic wr_status = reg_wr_in && (reg_addr_in == cim_pkg::ADDR_STATUS);
  wire logic wr_mask   = reg_wr_in && (reg_addr_in == cim_pkg::ADDR_MASK);
  assign status_d = (status_q & ~(wr_status ? reg_wdata_in[cim_pkg::EVT_W-1:0] : '0)) | evt;
  assign irq_out  = |(status_q & mask_q);

  // read mux, unmapped reads zero
  wire logic [31:0] rd_mux =
    (reg_addr_in == cim_pkg::ADDR_STATUS) ? {{(32-cim_pkg::EVT_W){1'b0}}, status_q} :
    (reg_addr_in == cim_pkg::ADDR_MASK)   ? {{(32-cim_pkg::EVT_W){1'b0}}, mask_q}   :
    (reg_addr_in == cim_pkg::ADDR_MODE)   ? {31'h0, mode_q} : 32'h0;

  // ==========================================================
  // register bus and core state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      status_q      <= cim_pkg::STATUS_RST;
      mask_q        <= cim_pkg::MASK_RST;
      reg_rdata_out <= 32'h0;
      ext_q         <= ST_IDLE;
      mode_q        <= cim_pkg::MODE_WIDE;
    end else begin
      status_q      <= status_d;
      mask_q        <= wr_mask ? reg_wdata_in[cim_pkg::EVT_W-1:0] : mask_q;
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
      ext_q         <= ext_d;
      mode_q        <= mode_d;
    end
  end

  // decode and jump answers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dec_valid_out    <= 1'b0;
      dec_rsp_out      <= '0;
      jmp_link_vld_out <= 1'b0;
      jmp_link_bit_out <= 1'b0;
      jmp_ri_out       <= 1'b0;
      jmp_addr_err_out <= 1'b0;
    end else begin
      dec_valid_out    <= dec_valid_in;
      dec_rsp_out      <= dec_valid_in ? rsp_d : '0;
      // link register bit 0 gets mode
      jmp_link_vld_out <= jv && k_link && !jmp_ri;
      jmp_link_bit_out <= mode_q;
      jmp_ri_out       <= jmp_ri;
      jmp_addr_err_out <= addr_err;
    end
  end

  // exception restart bit
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      exc_vld_out         <= 1'b0;
      exc_dest_out        <= cim_pkg::EX_NORMAL;
      exc_restart_bit_out <= 1'b0;
    end else begin
      exc_vld_out         <= exc_take_in;
      exc_dest_out        <= exc_take_in ? exc_kind_in : exc_dest_out;
      // interrupted mode into restart bit 0
      exc_restart_bit_out <= exc_take_in ? mode_q : exc_restart_bit_out;
    end
  end

  // reset vector fetch in wide mode
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rst_pend_q <= 1'b1;
      redir_q    <= 1'b0;
      pc_q       <= RESET_VEC;
    end else begin
      rst_pend_q <= 1'b0;
      redir_q    <= redirect;
      pc_q       <= redirect ? (HAS_COMPACT ? tgt_clr : jmp_target_in) : pc_q;
    end
  end

  assign fetch_mode_out     = mode_q;
  assign fetch_redirect_out = rst_pend_q || redir_q;
  assign fetch_pc_out       = pc_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  map_low_code_a: assert property (
    dec_valid_in && dec_req_in.cls != cim_pkg::CL_MOVE && dec_req_in.rx < 3'h2
    |=> dec_rsp_out.rx_idx == (5'h10 + {2'h0, $past(dec_req_in.rx)}))
    else $error("low compact code not remapped");

  flag_reg_use_a: assert property (
    dec_valid_in && dec_req_in.flag_use |=> dec_rsp_out.imp_vld && dec_rsp_out.imp_idx == 5'h18)
    else $error("flag instruction missed register 24");

  exc_mode_clr_a: assert property (
    exc_take_in |=> !fetch_mode_out && exc_vld_out)
    else $error("exception left compact mode set");

  restart_bit_a: assert property (
    exc_take_in |=> exc_restart_bit_out == $past(mode_q))
    else $error("restart bit does not hold interrupted mode");

  reset_fetch_a: assert property (
    rst_b_in && !$past(rst_b_in) |-> fetch_redirect_out && fetch_pc_out == RESET_VEC && !fetch_mode_out)
    else $error("reset fetch not at wide reset vector");

  link_mode_bit_a: assert property (
    jmp_valid_in && !exc_take_in && jmp_kind_in == cim_pkg::JK_JAL
    |=> jmp_link_vld_out && jmp_link_bit_out == $past(mode_q))
    else $error("link bit does not carry mode");

  exchange_flip_a: assert property (
    HAS_COMPACT && jmp_valid_in && !exc_take_in && jmp_kind_in == cim_pkg::JK_JUMP_LINK_EXCHANGE
    |=> mode_q != $past(mode_q))
    else $error("exchange jump did not flip mode");

  reg_jump_mode_a: assert property (
    HAS_COMPACT && jmp_valid_in && !exc_take_in && jmp_kind_in == cim_pkg::JK_JR
    |=> mode_q == $past(jmp_target_in[0]) && fetch_redirect_out && !fetch_pc_out[0] && !jmp_addr_err_out)
    else $error("register jump mode or pc bit 0 wrong");

  ext_misuse_a: assert property (
    dec_valid_in && dec_req_in.cls == cim_pkg::CL_EXTEND && !exc_take_in
    ##1 dec_valid_in && dec_req_in.cls == cim_pkg::CL_ALUR |=> dec_rsp_out.ri ##1 status_q[0])
    else $error("misplaced extend not reported");

  stack_reg_use_a: assert property (
    dec_valid_in && !dec_req_in.flag_use && dec_req_in.sp_use |=> dec_rsp_out.imp_idx == 5'h1d)
    else $error("stack instruction missed register 29");

  link_reg_use_a: assert property (
    dec_valid_in && !dec_req_in.flag_use && !dec_req_in.sp_use && dec_req_in.ra_use
    |=> dec_rsp_out.imp_idx == 5'h1f)
    else $error("link instruction missed register 31");

  move_any_reg_a: assert property (
    dec_valid_in && dec_req_in.cls == cim_pkg::CL_MOVE |=> dec_rsp_out.rx_idx == $past(dec_req_in.move_reg))
    else $error("move form lost full index");

  map_high_code_a: assert property (
    dec_valid_in && dec_req_in.cls != cim_pkg::CL_MOVE && dec_req_in.rx >= 3'h2
    |=> dec_rsp_out.rx_idx == {2'h0, $past(dec_req_in.rx)})
    else $error("high compact code remapped");

  map_ry_code_a: assert property (
    dec_valid_in && dec_req_in.ry < 3'h2 |=> dec_rsp_out.ry_idx == 5'h10 + $past(dec_req_in.ry))
    else $error("low second field not remapped");

  mode_read_a: assert property (
    reg_rd_in && reg_addr_in == 4'h8 |=> reg_rdata_out == {31'h0, $past(fetch_mode_out)})
    else $error("mode register read wrong");

  exc_dest_kind_a: assert property (
    exc_take_in |=> exc_dest_out == $past(exc_kind_in))
    else $error("restart register choice lost");

  exchange_link_a: assert property (
    HAS_COMPACT && jv && jmp_kind_in == cim_pkg::JK_JUMP_LINK_EXCHANGE
    |=> jmp_link_vld_out && jmp_link_bit_out == $past(mode_q))
    else $error("exchange jump link bit wrong");

  compact_jump_a: assert property (
    HAS_COMPACT && jv && jmp_kind_in == cim_pkg::JK_JRC && mode_q
    |=> mode_q == $past(jmp_target_in[0]) && fetch_redirect_out && !fetch_pc_out[0])
    else $error("compact register jump wrong");

  exchange_ri_a: assert property (
    !HAS_COMPACT && jv && jmp_kind_in == cim_pkg::JK_JUMP_LINK_EXCHANGE |=> jmp_ri_out && !jmp_link_vld_out)
    else $error("exchange jump taken without extension");

  odd_target_a: assert property (
    !HAS_COMPACT && jv && jmp_kind_in inside {cim_pkg::JK_JR, cim_pkg::JK_JUMP_LINK_VIA_REG} && jmp_target_in[0]
    |=> jmp_addr_err_out)
    else $error("odd target without address error");

  break_trap_a: assert property (
    dec_valid_in && dec_req_in.cls == cim_pkg::CL_BREAK |=> dec_rsp_out.brk && status_q[3])
    else $error("breakpoint not reported");

  macro_flag_a: assert property (
    dec_valid_in && dec_req_in.cls == cim_pkg::CL_MACRO |=> dec_rsp_out.macro)
    else $error("macro instruction not flagged");

  ext_twice_a: assert property (
    dec_valid_in && dec_req_in.cls == cim_pkg::CL_EXTEND && !exc_take_in
    ##1 dec_valid_in && dec_req_in.cls == cim_pkg::CL_EXTEND |=> dec_rsp_out.ri)
    else $error("extend after extend not reported");

  ext_allowed_a: assert property (
    dec_valid_in && dec_req_in.cls inside {cim_pkg::CL_LDST, cim_pkg::CL_SAVE, cim_pkg::CL_ALUI}
    |=> dec_rsp_out.extensible)
    else $error("extensible class not marked");

  ext_refused_a: assert property (
    dec_valid_in && dec_req_in.cls inside {cim_pkg::CL_ALUR, cim_pkg::CL_MOVE} |=> !dec_rsp_out.extensible)
    else $error("register class marked extensible");

  fetch_target_a: assert property (
    HAS_COMPACT && jv && jmp_kind_in inside {cim_pkg::JK_JR, cim_pkg::JK_JUMP_LINK_VIA_REG}
    |=> fetch_redirect_out && fetch_pc_out == {$past(jmp_target_in[31:1]), 1'b0})
    else $error("fetch not at cleared-bit target");

endmodule : cim_regmap

// file: dv/cim_fetch_model.sv
`timescale 1ns/1ps
// ==========================================================
// fetch unit stand-in: follows redirects, steps by instruction size
module cim_fetch_model (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        redirect_in,
  input  wire logic        mode_in,
  input  wire logic [31:0] pc_in,
  output logic      [31:0] fetch_addr_out
);
  logic [31:0] next_q;
  logic [31:0] next_d;

  assign fetch_addr_out = redirect_in ? pc_in : next_q;
  // halfword steps in compact mode, word steps otherwise
  assign next_d = fetch_addr_out + (mode_in ? 32'h2 : 32'h4);

  // next sequential fetch address
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) next_q <= 32'h0;
    else next_q <= next_d;
  end
endmodule : cim_fetch_model

// file: dv/tb_cim_regmap.sv
`timescale 1ns/1ps
module tb_cim_regmap;
  localparam logic [31:0] RST_VEC = 32'h0000_0400;
  // ==========================================================
  // stimulus and observed signals
  logic clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic dec_valid_in = 1'b0, jmp_valid_in = 1'b0, exc_take_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, jmp_target_in = 32'h0;
  cim_pkg::cim_dec_req_t dec_req_in = '0;
  cim_pkg::cim_jkind_t jmp_kind_in = cim_pkg::JK_JAL;
  cim_pkg::cim_exkind_t exc_kind_in = cim_pkg::EX_NORMAL;
  logic [31:0] reg_rdata_out, fetch_pc_out, fetch_addr;
  logic irq_out, dec_valid_out, jmp_link_vld_out, jmp_link_bit_out, jmp_ri_out, jmp_addr_err_out;
  logic exc_vld_out, exc_restart_bit_out, fetch_mode_out, fetch_redirect_out, nx_ri, nx_ae, nx_rd, rd_due;
  cim_pkg::cim_dec_rsp_t dec_rsp_out, ds;
  cim_pkg::cim_exkind_t exc_dest_out;
  int bad_count = 0, check_count = 0;
  logic m_mode = 1'b0, m_ext = 1'b0;
  logic [31:0] m_pc = RST_VEC;
  cim_pkg::cim_dec_rsp_t q_dec[$];
  logic [37:0] q_jmp[$];
  logic [3:0] q_exc[$];
  logic [31:0] q_rd[$];
  logic [2:0] q_nx[$];
  cim_pkg::cim_dec_req_t r;

  always #25 clk_in = ~clk_in;

  cim_regmap #(.HAS_COMPACT(1'b1), .RESET_VEC(RST_VEC)) cim_regmap_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
    .dec_valid_in(dec_valid_in), .dec_req_in(dec_req_in), .dec_valid_out(dec_valid_out), .dec_rsp_out(dec_rsp_out),
    .jmp_valid_in(jmp_valid_in), .jmp_kind_in(jmp_kind_in), .jmp_target_in(jmp_target_in),
    .jmp_link_vld_out(jmp_link_vld_out), .jmp_link_bit_out(jmp_link_bit_out), .jmp_ri_out(jmp_ri_out),
    .jmp_addr_err_out(jmp_addr_err_out), .exc_take_in(exc_take_in), .exc_kind_in(exc_kind_in),
    .exc_vld_out(exc_vld_out), .exc_dest_out(exc_dest_out), .exc_restart_bit_out(exc_restart_bit_out),
    .fetch_mode_out(fetch_mode_out), .fetch_redirect_out(fetch_redirect_out), .fetch_pc_out(fetch_pc_out));

  // build without the compact extension, same stimulus
  cim_regmap #(.HAS_COMPACT(1'b0), .RESET_VEC(RST_VEC)) cim_regmap_nx_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(), .irq_out(),
    .dec_valid_in(dec_valid_in), .dec_req_in(dec_req_in), .dec_valid_out(), .dec_rsp_out(),
    .jmp_valid_in(jmp_valid_in), .jmp_kind_in(jmp_kind_in), .jmp_target_in(jmp_target_in),
    .jmp_link_vld_out(), .jmp_link_bit_out(), .jmp_ri_out(nx_ri), .jmp_addr_err_out(nx_ae),
    .exc_take_in(exc_take_in), .exc_kind_in(exc_kind_in), .exc_vld_out(), .exc_dest_out(),
    .exc_restart_bit_out(), .fetch_mode_out(), .fetch_redirect_out(nx_rd), .fetch_pc_out());

  cim_fetch_model cim_fetch_model_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .redirect_in(fetch_redirect_out),
    .mode_in(fetch_mode_out), .pc_in(fetch_pc_out), .fetch_addr_out(fetch_addr));

  // ==========================================================
  // checking and verdict
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // drivers: rd, dec, jmp, exc and do_reset note their expected result
  task automatic strobe(input logic w, input logic rd, input logic d, input logic j, input logic x);
    reg_wr_in <= w;
    reg_rd_in <= rd;
    dec_valid_in <= d;
    jmp_valid_in <= j;
    exc_take_in <= x;
  endtask : strobe

  task automatic idle;
    @(posedge clk_in) strobe(0, 0, 0, 0, 0);
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in) strobe(1, 0, 0, 0, 0);
    reg_addr_in <= a;
    reg_wdata_in <= d;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in) strobe(0, 1, 0, 0, 0);
    reg_addr_in <= a;
    q_rd.push_back(e);
  endtask : rd

  function automatic logic [4:0] map3(input logic [2:0] c);
    return (c < 3'h2) ? 5'h10 + {2'b00, c} : {2'b00, c};
  endfunction : map3

  task automatic dec(input cim_pkg::cim_dec_req_t q);
    cim_pkg::cim_dec_rsp_t e;
    e = '0;
    e.rx_idx = (q.cls == cim_pkg::CL_MOVE) ? q.move_reg : map3(q.rx);
    e.ry_idx = map3(q.ry);
    e.imp_vld = q.flag_use | q.sp_use | q.ra_use;
    e.imp_idx = q.flag_use ? 5'h18 : q.sp_use ? 5'h1d : q.ra_use ? 5'h1f : 5'h00;
    e.extensible = (q.cls < cim_pkg::CL_ALUR);
    e.ri = m_ext & ~e.extensible;
    e.brk = (q.cls == cim_pkg::CL_BREAK);
    e.macro = (q.cls == cim_pkg::CL_MACRO);
    m_ext = (q.cls == cim_pkg::CL_EXTEND);
    q_dec.push_back(e);
    @(posedge clk_in) strobe(0, 0, 1, 0, 0);
    dec_req_in <= q;
  endtask : dec

  task automatic jmp(input cim_pkg::cim_jkind_t k, input logic [31:0] t);
    logic lnk, ri, rg, xri, nm;
    lnk = k inside {cim_pkg::JK_JAL, cim_pkg::JK_JUMP_LINK_EXCHANGE, cim_pkg::JK_JUMP_LINK_VIA_REG, cim_pkg::JK_JUMP_LINK_VIA_REG_HAZARD, cim_pkg::JK_COMPACT_JUMP_LINK_VIA_REG};
    xri = k inside {cim_pkg::JK_JRC, cim_pkg::JK_COMPACT_JUMP_LINK_VIA_REG};
    rg = !(k inside {cim_pkg::JK_JAL, cim_pkg::JK_JUMP_LINK_EXCHANGE});
    ri = xri & ~m_mode;
    if (!rg) t[0] = 1'b0;
    nm = rg ? t[0] : (k == cim_pkg::JK_JUMP_LINK_EXCHANGE) ^ m_mode;
    q_nx.push_back({xri | k == cim_pkg::JK_JUMP_LINK_EXCHANGE, rg & t[0] & ~xri, ~xri & ~(rg & t[0]) & k != cim_pkg::JK_JUMP_LINK_EXCHANGE});
    if (ri) q_jmp.push_back({4'b0010, 1'b0, m_mode, m_pc});
    else q_jmp.push_back({lnk, lnk & m_mode, 3'b001, nm, t[31:1], 1'b0});
    if (!ri) {m_mode, m_pc} = {nm, t[31:1], 1'b0};
    @(posedge clk_in) strobe(0, 0, 0, 1, 0);
    jmp_kind_in <= k;
    jmp_target_in <= t;
  endtask : jmp

  task automatic exc(input cim_pkg::cim_exkind_t k, input logic wj);
    q_exc.push_back({k, m_mode, 1'b0});
    {m_mode, m_ext} = 2'b00;
    @(posedge clk_in) strobe(0, 0, 0, wj, 1);
    exc_kind_in <= k;
    jmp_kind_in <= cim_pkg::JK_JUMP_LINK_EXCHANGE;
  endtask : exc

  task automatic do_reset;
    @(posedge clk_in) rst_b_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    q_jmp.push_back({5'b00001, 1'b0, RST_VEC});
    q_nx.push_back(3'b001);
    {m_mode, m_ext, m_pc} = {2'b00, RST_VEC};
    rst_b_in <= 1'b1;
  endtask : do_reset

  // ==========================================================
  // monitor: takes the oldest note whenever a result appears
  always @(posedge clk_in) rd_due <= reg_rd_in;
  always @(negedge clk_in) if (rst_b_in) begin
    ds = dec_rsp_out;
    if (!ds.imp_vld) ds.imp_idx = '0;
    if (rd_due) chk("read data", 64'(reg_rdata_out), 64'(q_rd.pop_front()));
    if (dec_valid_out) chk("decode", 64'(ds), 64'(q_dec.pop_front()));
    if (jmp_link_vld_out | jmp_ri_out | jmp_addr_err_out | fetch_redirect_out)
      chk("jump", 64'({jmp_link_vld_out, jmp_link_vld_out & jmp_link_bit_out, jmp_ri_out, jmp_addr_err_out,
          fetch_redirect_out, fetch_mode_out, fetch_pc_out}), 64'(q_jmp.pop_front()));
    if (exc_vld_out) chk("exception", 64'({exc_dest_out, exc_restart_bit_out, fetch_mode_out}), 64'(q_exc.pop_front()));
    if (nx_ri | nx_ae | nx_rd) chk("no extension", 64'({nx_ri, nx_ae, nx_rd}), 64'(q_nx.pop_front()));
    if (fetch_redirect_out & fetch_mode_out) chk("fetch align", 64'(fetch_addr[0]), 64'h0);
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hebda));
    do_reset();
    rd(cim_pkg::ADDR_STATUS, 32'h0);
    rd(cim_pkg::ADDR_MASK, 32'h0);
    rd(cim_pkg::ADDR_MODE, 32'h0);
    rd(4'hc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      jmp(cim_pkg::cim_jkind_t'(i), 32'h0000_1001);
      jmp(cim_pkg::cim_jkind_t'(i), 32'h0000_2000);
    end
    for (int i = 0; i < 60; i++) begin
      r = $bits(r)'($urandom);
      r.cls = cim_pkg::cim_class_t'($urandom_range(0, 10));
      dec(r);
      jmp(cim_pkg::cim_jkind_t'($urandom_range(0, 7)), $urandom);
    end
    for (int i = 0; i < 3; i++) begin
      jmp(cim_pkg::JK_JR, 32'h0000_0301);
      exc(cim_pkg::cim_exkind_t'(i), i == 1);
    end
    wr(cim_pkg::ADDR_STATUS, 32'hf);
    wr(cim_pkg::ADDR_MASK, 32'h0);
    r = '0;
    r.cls = cim_pkg::CL_EXTEND;
    dec(r);
    dec(r);
    exc(cim_pkg::EX_ERROR, 1'b0);
    dec(r);
    r.cls = cim_pkg::CL_LDST;
    dec(r);
    r.cls = cim_pkg::CL_EXTEND;
    dec(r);
    r.cls = cim_pkg::CL_ALUR;
    dec(r);
    r.cls = cim_pkg::CL_BREAK;
    dec(r);
    jmp(cim_pkg::JK_JRC, 32'h0000_0500);
    wr(cim_pkg::ADDR_MODE, 32'h1);
    rd(cim_pkg::ADDR_STATUS, 32'hb);
    rd(cim_pkg::ADDR_MODE, 32'h0);
    idle();
    @(negedge clk_in) chk("irq masked", 64'(irq_out), 64'h0);
    wr(cim_pkg::ADDR_MASK, 32'h1);
    idle();
    @(negedge clk_in) chk("irq raised", 64'(irq_out), 64'h1);
    wr(cim_pkg::ADDR_STATUS, 32'h1);
    idle();
    @(negedge clk_in) chk("irq cleared", 64'(irq_out), 64'h0);
    rd(cim_pkg::ADDR_STATUS, 32'ha);
    jmp(cim_pkg::JK_JR, 32'h0000_0501);
    idle();
    do_reset();
    rd(cim_pkg::ADDR_MODE, 32'h0);
    idle();
    repeat (3) @(posedge clk_in);
    chk("pending notes", 64'(q_dec.size() + q_jmp.size() + q_exc.size() + q_rd.size() + q_nx.size()),
        64'h0);
    report_and_stop();
  end

  // hang guard, far beyond the roughly 190 cycles of the run
  initial begin
    #(50 * 4000);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_cim_regmap
